// ### shared/gpp_defines.svh
// Constants for the general pin port
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH
// ==========================================================
// Sizes and reset values
`define GPP_NPINS 21
`define GPP_RST_DIR 21'h000000
`define GPP_RST_OUT 21'h000000
`define GPP_RST_PULL 21'h1fffff
`define GPP_RST_ZERO 21'h000000
`endif

// ### shared/gpp_pkg.sv
// Types shared by the general pin port
package gpp_pkg;
  // ==========================================================
  // Pin drive as seen at the pads
  typedef struct packed {
    logic [20:0] oe;
    logic [20:0] out;
    logic [20:0] pull;
  } gpp_pad_s;
  // ==========================================================
  // Power state of the port
  typedef enum logic [1:0] {
    GPP_AWAKE = 2'b00,
    GPP_ASLEEP = 2'b01,
    GPP_WAKING = 2'b10
  } gpp_pwr_e;
endpackage

// ### src/gpp_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module gpp_sync #(
  parameter int W = 21
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### src/gpp_port.sv
// General pin port with sleep hold and edge wake
// ==========================================================
// What this block does
// (R1) Twenty-one pins, each with own direction and own pull-up enable.
// (R2) An enabled peripheral overrides port direction and output of its pin.
// (R3) In and after reset: peripherals off, all pins inputs with pull-ups on.
// (R4) Without peripheral, software sets direction, writes output, reads level.
// (R5) Pull-up enable per pin, kept unchanged through sleep and wake.
// (R6) Input pins flag a selected rising or falling edge; per-pin enable.
// (R7) Enabled pin edge while asleep requests wake-up.
// (R8) Per-pin interrupt status is readable.
// (R9) Level readback shows the real pin state for inputs and outputs.
// (R10) Sleep entry captures effective direction and output, held while asleep.
// (R11) After wake the held values stay but belong to port settings.
// (R12) Peripherals come back disabled after wake until software re-enables.
// (R13) Peripheral output function makes the pin an output driven by it.
// (R14) Other party should leave unused pins as pulled-up inputs.
// (R15) Pin inputs pass two flip-flops before edge detect and readback.
// (R16) Status sticks until written one; interrupt output only when enabled.
`timescale 1ns/1ns
`include "gpp_defines.svh"
module gpp_port
  import gpp_pkg::*;
#(
  parameter int NPINS = `GPP_NPINS
) (
  input wire logic CLK,
  input wire logic SRST,
  // Pin pads
  input wire logic [NPINS-1:0] PIN_IN,
  output logic [NPINS-1:0] PIN_OUT,
  output logic [NPINS-1:0] PIN_OE,
  output logic [NPINS-1:0] PIN_PULLUP,
  // Port settings written by software
  input wire logic [NPINS-1:0] DIR_WDATA,
  input wire logic DIR_WE,
  input wire logic [NPINS-1:0] OUT_WDATA,
  input wire logic OUT_WE,
  input wire logic [NPINS-1:0] PULL_WDATA,
  input wire logic PULL_WE,
  input wire logic [NPINS-1:0] IEN_WDATA,
  input wire logic IEN_WE,
  input wire logic [NPINS-1:0] RISE_SEL_WDATA,
  input wire logic RISE_SEL_WE,
  input wire logic [NPINS-1:0] STAT_CLR,
  input wire logic [NPINS-1:0] PERI_EN_WDATA,
  input wire logic PERI_EN_WE,
  // Peripheral side of each pin
  input wire logic [NPINS-1:0] PERI_OE,
  input wire logic [NPINS-1:0] PERI_OUT,
  // Power control
  input wire logic SLEEP_REQ,
  input wire logic WAKE_DONE,
  // Status readback
  output logic [NPINS-1:0] DIR_Q,
  output logic [NPINS-1:0] OUT_Q,
  output logic [NPINS-1:0] PULL_Q,
  output logic [NPINS-1:0] IEN_Q,
  output logic [NPINS-1:0] PERI_EN_Q,
  output logic [NPINS-1:0] PIN_LEVEL,
  output logic [NPINS-1:0] INT_STATUS,
  output logic INT_OUT,
  output logic WAKE_REQ,
  output logic ASLEEP
);
  logic [NPINS-1:0] dir_r;
  logic [NPINS-1:0] out_r;
  logic [NPINS-1:0] pull_r;
  logic [NPINS-1:0] ien_r;
  logic [NPINS-1:0] rise_r;
  logic [NPINS-1:0] peri_en_r;
  logic [NPINS-1:0] stat_r;
  logic [NPINS-1:0] lvl_sync;
  logic [NPINS-1:0] lvl_prev_r;
  logic [NPINS-1:0] edge_hit;
  logic [NPINS-1:0] eff_oe;
  logic [NPINS-1:0] eff_out;
  logic [NPINS-1:0] hold_oe_r;
  logic [NPINS-1:0] hold_out_r;
  logic wake_r;
  gpp_pwr_e pwr_r;
  gpp_pwr_e pwr_nxt;
  gpp_pad_s pad;

  // ==========================================================
  // Input synchroniser
  gpp_sync #(
    .W(NPINS)
  ) u_sync (
    .clk(CLK),
    .srst(SRST),
    .d(PIN_IN),
    .q(lvl_sync)
  ); // see (R15)

  // ==========================================================
  // Port settings
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dir_r <= `GPP_RST_DIR; // see (R3)
    end else if (pwr_r == GPP_ASLEEP) begin
      dir_r <= hold_oe_r;
    end else if (pwr_r == GPP_WAKING) begin
      dir_r <= hold_oe_r; // see (R11)
    end else if (DIR_WE) begin
      dir_r <= DIR_WDATA; // see (R4)
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      out_r <= `GPP_RST_OUT;
    end else if (pwr_r != GPP_AWAKE) begin
      out_r <= hold_out_r; // see (R11)
    end else if (OUT_WE) begin
      out_r <= OUT_WDATA; // see (R4)
    end
  end

  // Pull-ups are never touched by the sleep logic
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pull_r <= `GPP_RST_PULL; // see (R3)
    end else if (PULL_WE) begin
      pull_r <= PULL_WDATA; // see (R5)
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ien_r <= `GPP_RST_ZERO;
      rise_r <= `GPP_RST_ZERO;
    end else begin
      if (IEN_WE) begin
        ien_r <= IEN_WDATA; // see (R6)
      end
      if (RISE_SEL_WE) begin
        rise_r <= RISE_SEL_WDATA; // see (R6)
      end
    end
  end

  // Peripheral enables drop on the capture edge so wake hands pins to the port
  always_ff @(posedge CLK) begin
    if (SRST) begin
      peri_en_r <= `GPP_RST_ZERO; // see (R3)
    end else if (pwr_r != GPP_AWAKE || SLEEP_REQ) begin
      peri_en_r <= `GPP_RST_ZERO; // see (R12)
    end else if (PERI_EN_WE) begin
      peri_en_r <= PERI_EN_WDATA;
    end
  end

  // ==========================================================
  // Effective pin drive
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (peri_en_r[i]) begin
        eff_oe[i] = PERI_OE[i]; // see (R2) (R13)
        eff_out[i] = PERI_OUT[i];
      end else begin
        eff_oe[i] = dir_r[i];
        eff_out[i] = out_r[i];
      end
    end
  end

  // ==========================================================
  // Sleep hold
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      GPP_AWAKE: begin
        if (SLEEP_REQ) begin
          pwr_nxt = GPP_ASLEEP;
        end
      end
      GPP_ASLEEP: begin
        if (WAKE_DONE) begin
          pwr_nxt = GPP_WAKING;
        end
      end
      GPP_WAKING: begin
        pwr_nxt = GPP_AWAKE;
      end
      default: begin
        pwr_nxt = GPP_AWAKE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pwr_r <= GPP_AWAKE;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      hold_oe_r <= `GPP_RST_ZERO;
      hold_out_r <= `GPP_RST_ZERO;
    end else if (pwr_r == GPP_AWAKE && SLEEP_REQ) begin
      hold_oe_r <= eff_oe; // see (R10)
      hold_out_r <= eff_out;
    end
  end

  // Pads show held values from the capture edge until wake completes
  always_comb begin
    if (pwr_r == GPP_AWAKE) begin
      pad.oe = eff_oe;
      pad.out = eff_out;
    end else begin
      pad.oe = hold_oe_r; // see (R10)
      pad.out = hold_out_r;
    end
    pad.pull = pull_r; // see (R1) (R5)
  end

  assign PIN_OE = pad.oe;
  assign PIN_OUT = pad.out;
  assign PIN_PULLUP = pad.pull;

  // ==========================================================
  // Edge detection and status
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lvl_prev_r <= `GPP_RST_ZERO;
    end else begin
      lvl_prev_r <= lvl_sync;
    end
  end

  // Output pins never flag; their level is ours, not an event
  assign edge_hit = ~pad.oe & ((rise_r & lvl_sync & ~lvl_prev_r) |
                               (~rise_r & ~lvl_sync & lvl_prev_r)); // see (R6)

  // A new edge beats a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat_r <= `GPP_RST_ZERO;
    end else begin
      stat_r <= (stat_r & ~STAT_CLR) | edge_hit; // see (R16)
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= (pwr_r == GPP_ASLEEP) && |(edge_hit & ien_r); // see (R7)
    end
  end

  // ==========================================================
  // Readback
  assign DIR_Q = dir_r;
  assign OUT_Q = out_r;
  assign PULL_Q = pull_r;
  assign IEN_Q = ien_r;
  assign PERI_EN_Q = peri_en_r;
  assign PIN_LEVEL = lvl_sync; // see (R9)
  assign INT_STATUS = stat_r; // see (R8)
  assign INT_OUT = |(stat_r & ien_r); // see (R16)
  assign WAKE_REQ = wake_r;
  assign ASLEEP = (pwr_r == GPP_ASLEEP);
endmodule

// ### dv/gpp_pads.sv
// External circuitry model on the port pins
`timescale 1ns/1ns
module gpp_pads
  import gpp_pkg::*;
(
  input wire logic clk,
  input wire gpp_pad_s pad,
  input wire logic [20:0] ext_en,
  input wire logic [20:0] ext_val,
  output logic [20:0] pin_in
);
  // ==========
  // Pin levels
  logic [20:0] float_r = 21'h0;
  // A floating pin wanders, so nothing may rely on its old level
  always @(posedge clk) float_r <= ~float_r;
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
    | (~pad.oe & ~ext_en & (pad.pull | float_r));
endmodule

// ### dv/gpp_port_monitor.sv
// Checker bound to the general pin port
`timescale 1ns/1ns
module gpp_port_monitor
  import gpp_pkg::*;
#(
  parameter int NPINS = 21
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SLEEP_REQ,
  input wire logic INT_OUT,
  input wire logic ASLEEP,
  input wire logic [NPINS-1:0] PIN_IN,
  input wire logic [NPINS-1:0] PIN_OUT,
  input wire logic [NPINS-1:0] PIN_OE,
  input wire logic [NPINS-1:0] STAT_CLR,
  input wire logic [NPINS-1:0] PERI_OE,
  input wire logic [NPINS-1:0] DIR_Q,
  input wire logic [NPINS-1:0] IEN_Q,
  input wire logic [NPINS-1:0] PERI_EN_Q,
  input wire logic [NPINS-1:0] PIN_LEVEL,
  input wire logic [NPINS-1:0] INT_STATUS
);
  // ==========
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_rst; disable iff (1'b0) SRST |=> PIN_OE == '0 && PERI_EN_Q == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_irq; INT_OUT == |(INT_STATUS & IEN_Q); endproperty
  a_irq: assert property (p_irq) else $error("irq output");
  property p_drv; !ASLEEP |-> PIN_OE == (PERI_EN_Q & PERI_OE | ~PERI_EN_Q & DIR_Q); endproperty
  a_drv: assert property (p_drv) else $error("pin direction");
  property p_hold;
    ASLEEP && $past(ASLEEP) |-> $stable(PIN_OE) && $stable(PIN_OUT & PIN_OE);
  endproperty
  a_hold: assert property (p_hold) else $error("sleep hold");
  property p_cap; SLEEP_REQ && !ASLEEP |=> ASLEEP && PERI_EN_Q == '0 && $stable(PIN_OE); endproperty
  a_cap: assert property (p_cap) else $error("sleep entry");
  property p_lvl; !$past(SRST) && !$past(SRST, 2) |-> PIN_LEVEL == $past(PIN_IN, 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level sync");
  property p_stat; !$past(SRST) |-> ($past(INT_STATUS) & ~$past(STAT_CLR) & ~INT_STATUS) == '0;
  endproperty
  a_stat: assert property (p_stat) else $error("status lost");
  property p_wake; $fell(ASLEEP) && !$past(SRST) |-> $stable(PIN_OE) && DIR_Q == PIN_OE; endproperty
  a_wake: assert property (p_wake) else $error("wake handover");
endmodule
bind gpp_port gpp_port_monitor #(.NPINS(NPINS)) gpp_port_monitor_i (.*);

// ### dv/testbench.sv
// Self-checking bench for the general pin port
`timescale 1ns/1ns
module testbench
  import gpp_pkg::*;
;
  // ==========
  // Signals
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic SLEEP_REQ = 1'b0;
  logic WAKE_DONE = 1'b0;
  logic [5:0] we = 6'h0;
  logic [20:0] wd = 21'h0;
  logic [20:0] STAT_CLR = 21'h0;
  logic [20:0] PERI_OE = 21'h13;
  logic [20:0] PERI_OUT = 21'h12;
  logic [20:0] ext_val = 21'ha5a50;
  logic [20:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, DIR_Q, OUT_Q, PULL_Q, IEN_Q;
  logic [20:0] PERI_EN_Q, PIN_LEVEL, INT_STATUS;
  logic INT_OUT, WAKE_REQ, ASLEEP;
  wire DIR_WE, OUT_WE, PULL_WE, IEN_WE, RISE_SEL_WE, PERI_EN_WE;
  wire [20:0] DIR_WDATA = wd, OUT_WDATA = wd, PULL_WDATA = wd;
  wire [20:0] IEN_WDATA = wd, RISE_SEL_WDATA = wd, PERI_EN_WDATA = wd;
  wire gpp_pad_s pad = {PIN_OE, PIN_OUT, PIN_PULLUP};
  int mismatches = 0;
  int total_checks = 0;
  assign {PERI_EN_WE, RISE_SEL_WE, IEN_WE, PULL_WE, OUT_WE, DIR_WE} = we;
  always #10 CLK = ~CLK;
  gpp_port gpp_port_i (.*);
  gpp_pads gpp_pads_i (.clk(CLK), .pad(pad), .ext_en(21'h1ffff0), .ext_val(ext_val),
    .pin_in(PIN_IN));
  // ==========
  // Tasks
  task automatic cy(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input int k, input logic [20:0] d);
    @(posedge CLK);
    wd <= d;
    we <= 6'h1 << k;
    @(posedge CLK);
    we <= 6'h0;
  endtask
  task automatic clr(input logic [20:0] m);
    @(posedge CLK) STAT_CLR <= m;
    @(posedge CLK) STAT_CLR <= 21'h0;
    cy(1);
  endtask
  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Scenarios
  initial begin
    int n;
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    cy(1);
    chk("oe", PIN_OE, 21'h0);
    chk("pull", PIN_PULLUP, 21'h1fffff);
    chk("peri", PERI_EN_Q, 21'h0);
    wr(0, 21'hf);
    wr(1, 21'h5);
    wr(2, 21'hf0);
    cy(4);
    chk("oe", PIN_OE, 21'hf);
    chk("level", PIN_LEVEL, 21'ha5a55);
    chk("pull", PIN_PULLUP, 21'hf0);
    chk("pullq", PULL_Q, 21'hf0);
    wr(5, 21'h3);
    cy(1);
    chk("out", PIN_OUT & PIN_OE, 21'h6);
    chk("oe", PIN_OE, 21'hf);
    wr(4, 21'h50);
    wr(3, 21'h30);
    @(posedge CLK) ext_val <= 21'ha5a20;
    cy(4);
    clr(21'h1fffff);
    chk("stat", INT_STATUS, 21'h0);
    @(posedge CLK) ext_val <= 21'ha5a50;
    cy(5);
    chk("stat", INT_STATUS, 21'h70);
    chk("irq", INT_OUT, 1'b1);
    wr(3, 21'h0);
    cy(1);
    chk("ienq", IEN_Q, 21'h0);
    chk("irq", INT_OUT, 1'b0);
    clr(21'h30);
    chk("stat", INT_STATUS, 21'h40);
    @(posedge CLK) SLEEP_REQ <= 1'b1;
    @(posedge CLK) SLEEP_REQ <= 1'b0;
    PERI_OUT <= 21'h0;
    wr(1, 21'h0);
    wr(3, 21'h10);
    @(posedge CLK) ext_val <= 21'ha5a40;
    cy(5);
    chk("asleep", ASLEEP, 1'b1);
    chk("peri", PERI_EN_Q, 21'h0);
    chk("out", PIN_OUT & PIN_OE, 21'h6);
    chk("pull", PIN_PULLUP, 21'hf0);
    @(posedge CLK) ext_val <= 21'ha5a50;
    n = 0;
    while (WAKE_REQ !== 1'b1 && n < 10) begin
      cy(1);
      n++;
    end
    chk("wake", WAKE_REQ, 1'b1);
    if (n == 10) summarize();
    @(posedge CLK) WAKE_DONE <= 1'b1;
    @(posedge CLK) WAKE_DONE <= 1'b0;
    cy(2);
    chk("wake", WAKE_REQ, 1'b0);
    chk("asleep", ASLEEP, 1'b0);
    chk("dir", DIR_Q, 21'hf);
    chk("outq", OUT_Q & 21'hf, 21'h6);
    chk("out", PIN_OUT & PIN_OE, 21'h6);
    chk("pull", PIN_PULLUP, 21'hf0);
    wr(5, 21'h3);
    cy(1);
    chk("out", PIN_OUT & PIN_OE, 21'h4);
    summarize();
  end
endmodule
